// File: rtl/fault_interrupt_status.sv
// Fault and status interrupt latches, masks and alert pin driver
`timescale 1ns/1ps
`include "fault_irq_consts.svh"
module fault_interrupt_status #(
  parameter logic [`TICK_W-1:0] PULSE_HALF_CYC = `TICK_W'(`PULSE_HALF_CYC),
  parameter logic [`TICK_W-1:0] RETRY_SLOW_CYC = `TICK_W'(`RETRY_SLOW_CYC),
  parameter logic [`TICK_W-1:0] RETRY_FAST_CYC = `TICK_W'(`RETRY_FAST_CYC)
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Supply monitor levels from the analog side
  input  wire logic       core_supply_ok_i,
  input  wire logic       io_supply_ok_i,
  // Hardware shutdown pin, low active
  input  wire logic       shutdown_pin_n_i,
  // Live device state
  input  wire logic       device_active_i,
  // Event sources, one vector per latch register
  input  wire logic [7:0] evt0_i,
  input  wire logic [7:0] evt1_i,
  input  wire logic [7:0] evt2_i,
  input  wire logic [7:0] evt3_i,
  input  wire logic [7:0] evt4_i,
  // Register access port from the serial control target
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  // Alert pin, open drain
  output logic            fault_alert_pin_o,
  output logic            fault_alert_pin_oe_o,
  output logic            alert_pullup_enable_o,
  // Side effects for the rest of the device
  output logic            retry_tick_o,
  output logic            soft_reset_o,
  output logic            config_reset_o
);

  // Number of mask and latch register pairs
  localparam int NR = `NUM_IRQ_REGS;

  // Two-stage synchronisers for pin-level inputs
  logic core_ok_s1_r;
  logic core_ok_s2_r;
  logic io_ok_s1_r;
  logic io_ok_s2_r;
  logic sdz_s1_r;
  logic sdz_s2_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_ok_s1_r <= 1'b0;
      core_ok_s2_r <= 1'b0;
      io_ok_s1_r   <= 1'b0;
      io_ok_s2_r   <= 1'b0;
      sdz_s1_r     <= 1'b0;
      sdz_s2_r     <= 1'b0;
    end else begin
      core_ok_s1_r <= core_supply_ok_i;
      core_ok_s2_r <= core_ok_s1_r;
      io_ok_s1_r   <= io_supply_ok_i;
      io_ok_s2_r   <= io_ok_s1_r;
      sdz_s1_r     <= shutdown_pin_n_i;
      sdz_s2_r     <= sdz_s1_r;
    end
  end

  // Either supply missing or dipping forces defaults: configuration and masks reset, latches wiped, pin request silenced
  logic supply_bad;
  assign supply_bad = ~(core_ok_s2_r & io_ok_s2_r);

  // Self-clearing command strobes
  logic latch_clr_r;
  logic soft_rst_r;
  logic cfg_wr;
  logic defaults;
  logic latch_wipe;

  // Write strobe of the configuration register
  assign cfg_wr     = reg_wr_i & (reg_addr_i == `OFS_CFG);
  // Soft reset takes one cycle; the bit reads back zero once it is done
  assign defaults   = supply_bad | soft_rst_r;
  // Any clear source wipes the latches
  assign latch_wipe = defaults | latch_clr_r | ~sdz_s2_r;

  // Latch-clear strobe lasts one cycle, so the bit never stays set
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_clr_r <= 1'b0;
    end else if (defaults) begin
      latch_clr_r <= 1'b0;
    end else begin
      latch_clr_r <= cfg_wr & reg_wdata_i[`CFG_LATCH_CLR];
    end
  end

  // Soft-reset strobe; the defaults it raises cancel it on the next edge
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      soft_rst_r  <= 1'b0;
    end else if (defaults) begin
      soft_rst_r  <= 1'b0;
    end else begin
      soft_rst_r  <= cfg_wr & reg_wdata_i[`CFG_SOFT_RST];
    end
  end

  // Configuration register: pull-up, pin behaviour, polarity, retry
  fault_irq_pkg::reg8_t cfg_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_r <= `CFG_RST;
    end else if (defaults) begin
      cfg_r <= `CFG_RST;
    end else if (cfg_wr) begin
      cfg_r <= reg_wdata_i & `CFG_WMASK;
    end
  end

  // Pin behaviour field seen as an enum for the decision below
  fault_irq_pkg::pin_beh_e pin_beh;
  assign pin_beh = fault_irq_pkg::pin_beh_e'(cfg_r[`CFG_PINBEH_HI:`CFG_PINBEH_LO]);

  // Constant tables of implemented bits and mask defaults
  fault_irq_pkg::reg8_t impl_tbl [NR];
  fault_irq_pkg::reg8_t mrst_tbl [NR];
  fault_irq_pkg::reg8_t evt_vec  [NR];

  // Positions and defaults
  assign impl_tbl[0] = `IMPL_0;
  assign impl_tbl[1] = `IMPL_1;
  assign impl_tbl[2] = `IMPL_2;
  assign impl_tbl[3] = `IMPL_3;
  assign impl_tbl[4] = `IMPL_4;
  assign mrst_tbl[0] = `MASK_RST_0;
  assign mrst_tbl[1] = `MASK_RST_1;
  assign mrst_tbl[2] = `MASK_RST_2;
  assign mrst_tbl[3] = `MASK_RST_3;
  assign mrst_tbl[4] = `MASK_RST_4;
  assign evt_vec[0]  = evt0_i;
  assign evt_vec[1]  = evt1_i;
  assign evt_vec[2]  = evt2_i;
  assign evt_vec[3]  = evt3_i;
  assign evt_vec[4]  = evt4_i;

  // Mask and latch storage
  fault_irq_pkg::reg8_t mask_r  [NR];
  fault_irq_pkg::reg8_t latch_r [NR];
  fault_irq_pkg::reg8_t view    [NR];
  logic [NR-1:0]        pend_vec;

  // One copy of mask, latch and read view per register
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_regs
      logic mask_wr;
      assign mask_wr = reg_wr_i & (reg_addr_i == (`OFS_MASK_BASE + 4'(g)));

      // Constant default so the async reset already shows the documented masks
      localparam fault_irq_pkg::reg8_t MASK_DEF = (g == 0) ? `MASK_RST_0 :
                                                  (g == 1) ? `MASK_RST_1 :
                                                  (g == 2) ? `MASK_RST_2 :
                                                  (g == 3) ? `MASK_RST_3 :
                                                             `MASK_RST_4;

      // Mask bits only steer the pin; defaults return on any reset
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          mask_r[g] <= MASK_DEF;
        end else if (defaults) begin
          mask_r[g] <= mrst_tbl[g];
        end else if (mask_wr) begin
          mask_r[g] <= reg_wdata_i & impl_tbl[g];
        end
      end

      // Sticky latches; a new event in the clearing cycle survives the clear
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          latch_r[g] <= '0;
        end else begin
          latch_r[g] <= ((latch_wipe ? 8'h00 : latch_r[g])
                        | evt_vec[g]) & impl_tbl[g];
        end
      end

      // The device-active position carries the live state, not a latch
      if (g == 0) begin : g_live
        assign view[g] = {latch_r[g][7:2], device_active_i, latch_r[g][0]};
      end else begin : g_plain
        assign view[g] = latch_r[g];
      end

      assign pend_vec[g] = |(view[g] & ~mask_r[g]);
    end
  endgenerate

  // Keep the pin quiet on the first edge out of reset, before the sync settles
  logic boot_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  // Pin request: any unmasked bit, silenced while defaults are forced
  logic pending;
  assign pending = |pend_vec & ~boot_r & ~defaults;

  // Register read-back; latch-clear and soft-reset bits read as zero
  fault_irq_pkg::reg8_t rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr_i == `OFS_CFG) begin
      rd_mux = cfg_r;
    end else if (reg_addr_i < `OFS_LATCH_BASE) begin
      rd_mux = mask_r[3'(reg_addr_i)];
    end else if (reg_addr_i < (`OFS_LATCH_BASE + 4'(NR))) begin
      rd_mux = view[3'(reg_addr_i - `OFS_LATCH_BASE)];
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // Pulse mode timebase; restarts when pending rises so the first burst is full
  logic pending_d_r;
  logic half_tick;
  logic pulse_on_r;

  // Previous pending level for the rise detector
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending_d_r <= 1'b0;
    end else begin
      pending_d_r <= pending;
    end
  end

  tick_divider u_pulse_div (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .restart_i (pending & ~pending_d_r),
    .period_i  (PULSE_HALF_CYC),
    .tick_o    (half_tick)
  );

  // On for one half period, off for the next: 2 ms of every 4 ms
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pulse_on_r <= 1'b0;
    end else if (pending & ~pending_d_r) begin
      pulse_on_r <= 1'b1;
    end else if (half_tick) begin
      pulse_on_r <= ~pulse_on_r;
    end
  end

  // Assert decision; reserved behaviour codes act as level mode
  logic want_assert;

  always_comb begin
    case (pin_beh)
      fault_irq_pkg::BEH_LEVEL:  want_assert = pending;
      fault_irq_pkg::BEH_PULSE:  want_assert = pending & pulse_on_r;
      fault_irq_pkg::BEH_RSVD_A: want_assert = pending;
      fault_irq_pkg::BEH_RSVD_B: want_assert = pending;
      default:                   want_assert = pending;
    endcase
  end

  // Open drain only ever pulls low; active high means pulling low when idle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_alert_pin_o     <= 1'b0;
      fault_alert_pin_oe_o  <= 1'b0;
    end else begin
      fault_alert_pin_o     <= 1'b0;
      fault_alert_pin_oe_o  <= cfg_r[`CFG_POLARITY] ? ~want_assert
                                                    : want_assert;
    end
  end

  // Internal pull-up follows its configuration bit; off while in reset
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      alert_pullup_enable_o <= 1'b0;
    end else begin
      alert_pullup_enable_o <= cfg_r[`CFG_PULLUP];
    end
  end

  // Retry interval for auto-retrying faults
  logic retry_tick;
  logic retry_change;
  logic retry_restart_r;

  // A change of the interval bit restarts the count at the new length
  assign retry_change = cfg_wr & (reg_wdata_i[`CFG_RETRY] != cfg_r[`CFG_RETRY]);

  // Registered so the reload sees the updated bit, not the old period
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      retry_restart_r <= 1'b1;
    end else begin
      retry_restart_r <= defaults | retry_change;
    end
  end

  tick_divider u_retry_div (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .restart_i (retry_restart_r),
    .period_i  (cfg_r[`CFG_RETRY] ? RETRY_FAST_CYC : RETRY_SLOW_CYC),
    .tick_o    (retry_tick)
  );

  // Registered side-effect outputs
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      retry_tick_o   <= 1'b0;
      soft_reset_o   <= 1'b0;
      config_reset_o <= 1'b1;
    end else begin
      retry_tick_o   <= retry_tick;
      // Channels power down at once on a soft reset
      soft_reset_o   <= cfg_wr & reg_wdata_i[`CFG_SOFT_RST];
      config_reset_o <= defaults;
    end
  end

endmodule

// File: rtl/fault_irq_consts.svh
// Offsets, field layouts, reset values and timing counts of the fault interrupt block
// Operation
// - Hold reset until both supplies valid
// - Supply undervoltage dip resets everything at once
// - Mask blocks pin, latch still records
// - Register 0 protection event bit positions
// - Supply monitor event bit positions
// - Thermal warnings masked, over-temperature unmasked
// - Clock protection event bit positions
// - Watchdog, over-current, device-active positions
// - Open-drain alert pin, asserts on faults
// - Pull-up enable bit connects internal pull-up
// - Behaviour 01: level on unmasked latch
// - Pulse mode: 2ms of every 4ms
// - Retry interval bit: 1.5s or 100ms
// - Polarity bit selects active high
// - Latch-clear bit clears latches, self-clears
// - Shutdown pin or soft reset clears latches
// - Device-active bit shows live state
// - Soft reset restores defaults, self-clears
`ifndef FAULT_IRQ_CONSTS_SVH
`define FAULT_IRQ_CONSTS_SVH

// Register offsets
`define OFS_MASK_BASE    4'h0
`define OFS_LATCH_BASE   4'h5
`define OFS_CFG          4'ha
`define NUM_IRQ_REGS     5

// Implemented bits per mask/latch register
`define IMPL_0           8'hfe
`define IMPL_1           8'hde
`define IMPL_2           8'hbf
`define IMPL_3           8'h8c
`define IMPL_4           8'h84

// Mask reset values (1 = masked)
`define MASK_RST_0       8'h02
`define MASK_RST_1       8'h1e
`define MASK_RST_2       8'h00
`define MASK_RST_3       8'h00
`define MASK_RST_4       8'h00

// Named event bit positions
`define BIT_BROWNOUT     3
`define BIT_GUARD_ACT    2
`define BIT_GUARD_HOLD   7
`define BIT_LIM_ACT      4
`define BIT_LIM_ATTEN    6
`define BIT_INFLECT      5
`define BIT_DEV_ACTIVE   1
`define BIT_PVDD_OV      2
`define BIT_PVDD_UV      7
`define BIT_TWO_CELL_BATTERY_SUPPLY_UV    6
`define BIT_VBAT_UV      7
`define BIT_TW_135       4
`define BIT_TW_105       1
`define BIT_OVERTEMP     7
`define BIT_CLK_ERR      3
`define BIT_CLK_RATIO    2
`define BIT_FS_CHANGE    1
`define BIT_FS_INVALID   0
`define BIT_FRAME_SYNC   5
`define BIT_PLL_ERR      4
`define BIT_PREPWR_CLK   2
`define BIT_WATCHDOG     7
`define BIT_OVERCURRENT  3

// Configuration register fields
`define CFG_PULLUP       0
`define CFG_PINBEH_LO    1
`define CFG_PINBEH_HI    2
`define CFG_POLARITY     3
`define CFG_RETRY        4
`define CFG_LATCH_CLR    5
`define CFG_SOFT_RST     6
`define CFG_RST          8'h02
`define CFG_WMASK        8'h1f

// Timing
`define CLK_MHZ          100
`define PULSE_HALF_US    2000
`define RETRY_SLOW_MS    1500
`define RETRY_FAST_MS    100
`define PULSE_HALF_CYC   (`PULSE_HALF_US * `CLK_MHZ)
`define RETRY_SLOW_CYC   (`RETRY_SLOW_MS * 1000 * `CLK_MHZ)
`define RETRY_FAST_CYC   (`RETRY_FAST_MS * 1000 * `CLK_MHZ)
`define TICK_W           28

`endif

// File: rtl/fault_irq_pkg.sv
// Types shared by the fault interrupt block
`include "fault_irq_consts.svh"
package fault_irq_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [`TICK_W-1:0] tick_cnt_t;
  typedef enum logic [1:0] {
    BEH_RSVD_A = 2'b00,
    BEH_LEVEL  = 2'b01,
    BEH_RSVD_B = 2'b10,
    BEH_PULSE  = 2'b11
  } pin_beh_e;
endpackage

// File: rtl/tick_divider.sv
// Restartable enable-pulse divider with a run-time period
`timescale 1ns/1ps
`include "fault_irq_consts.svh"
module tick_divider (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              restart_i,
  input  wire logic [`TICK_W-1:0] period_i,
  output logic                   tick_o
);
  logic [`TICK_W-1:0] cnt_r;

  // Count down; one-cycle tick when the count wraps
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      cnt_r  <= period_i - `TICK_W'(1);
      tick_o <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r  <= period_i - `TICK_W'(1);
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - `TICK_W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule

// File: dv/fault_irq_asserts.sv
// Port-level assertions for the fault interrupt block
`timescale 1ns/1ps
`include "fault_irq_consts.svh"
module fault_irq_asserts (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       core_supply_ok_i,
  input wire logic       io_supply_ok_i,
  input wire logic       device_active_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       fault_alert_pin_o,
  input wire logic       retry_tick_o,
  input wire logic       soft_reset_o,
  input wire logic       config_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Supply loss forces defaults once past the two-stage sync
  a_core_dip_rst: assert property (!core_supply_ok_i [*5] |-> config_reset_o)
    else $error("core supply loss kept config");
  a_io_dip_rst: assert property (!io_supply_ok_i [*5] |-> config_reset_o)
    else $error("io supply loss kept config");
  // The pin only ever pulls low
  a_alert_open_drain: assert property (!fault_alert_pin_o)
    else $error("alert pin driven high");
  // Soft reset is a single pulse and comes only from a register write
  a_soft_rst_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  a_soft_rst_cause: assert property ($rose(soft_reset_o) |->
    ($past(reg_wr_i) && $past(reg_wdata_i[6])) ||
    ($past(reg_wr_i, 2) && $past(reg_wdata_i[6], 2)))
    else $error("soft reset without write");
  a_soft_rst_cfg: assert property (soft_reset_o |-> ##[0:2] config_reset_o)
    else $error("soft reset kept config");
  // Shortest retry period is well above eight cycles
  a_retry_spacing: assert property (retry_tick_o |=> !retry_tick_o [*8])
    else $error("retry ticks too close");
  // Self-clearing command bits never read back as one
  a_cmd_bits_zero: assert property ((reg_rd_i && reg_addr_i == `OFS_CFG) ##1
    !reg_rd_i [*2] |-> reg_rdata_o[6:5] == 2'b00)
    else $error("command bits read as set");
  // Device-active status follows the live input
  a_active_live: assert property ((reg_rd_i && reg_addr_i == `OFS_LATCH_BASE &&
    device_active_i && $past(device_active_i)) ##1 !reg_rd_i [*2] |-> reg_rdata_o[1])
    else $error("active status not shown");
  c_soft_rst: cover property (soft_reset_o);
  c_retry: cover property (retry_tick_o);
  c_cfg_rst_end: cover property ($fell(config_reset_o));
endmodule
bind fault_interrupt_status fault_irq_asserts u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .core_supply_ok_i(core_supply_ok_i),
  .io_supply_ok_i(io_supply_ok_i), .device_active_i(device_active_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fault_alert_pin_o(fault_alert_pin_o),
  .retry_tick_o(retry_tick_o), .soft_reset_o(soft_reset_o), .config_reset_o(config_reset_o));

// File: dv/host_model.sv
// Host side: register master and the pulled-up alert line
`timescale 1ns/1ps
`include "fault_irq_consts.svh"
module host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       alert_oe_i,
  input  wire logic       alert_data_i,
  output logic [3:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            alert_line_o
);
  // Line is low only while the block pulls it; otherwise a pull-up wins
  assign alert_line_o = alert_oe_i ? alert_data_i : 1'b1;
  initial begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Requests launch on the falling edge and span one rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge ref_clk_i);
    wr_o = 1'b0;
  endtask
  // Data is taken one full cycle after the strobe drops, which covers the one-cycle read latency
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge ref_clk_i);
    rd_o = 1'b0;
    @(negedge ref_clk_i);
    d = rdata_i;
  endtask
  // Acknowledge all latched events; the bit needs no second write
  task automatic clear(input logic [7:0] cfg);
    wr(`OFS_CFG, cfg | 8'h20);
  endtask
endmodule

// File: dv/fault_interrupt_status_tb.sv
// Self-checking bench for the fault interrupt block
`timescale 1ns/1ps
`include "fault_irq_consts.svh"
module fault_interrupt_status_tb;
  logic       ref_clk_i, reset_i, core_ok, io_ok, sd_n, dev_act;
  logic       wr, rd, oe, dout, pu, tick, srst, crst, line;
  logic [7:0] evt [5];
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         n, k;
  localparam logic [7:0] mask_rst [5] = '{`MASK_RST_0, `MASK_RST_1, `MASK_RST_2,
                                          `MASK_RST_3, `MASK_RST_4};
  localparam logic [7:0] impl [5] = '{`IMPL_0, `IMPL_1, `IMPL_2, `IMPL_3, `IMPL_4};

  // Short counts keep pulse and retry windows within a brief run
  fault_interrupt_status #(.PULSE_HALF_CYC(28'd8), .RETRY_SLOW_CYC(28'd40),
    .RETRY_FAST_CYC(28'd12)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .core_supply_ok_i(core_ok),
    .io_supply_ok_i(io_ok), .shutdown_pin_n_i(sd_n), .device_active_i(dev_act),
    .evt0_i(evt[0]), .evt1_i(evt[1]), .evt2_i(evt[2]), .evt3_i(evt[3]), .evt4_i(evt[4]),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .fault_alert_pin_o(dout), .fault_alert_pin_oe_o(oe),
    .alert_pullup_enable_o(pu), .retry_tick_o(tick), .soft_reset_o(srst),
    .config_reset_o(crst));
  host_model u_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .alert_oe_i(oe),
    .alert_data_i(dout), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .alert_line_o(line));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    check(v, e);
  endtask
  task automatic pulse(input int i, input logic [7:0] b);
    @(negedge ref_clk_i);
    evt[i] = b;
    @(negedge ref_clk_i);
    evt[i] = 8'h00;
  endtask
  task automatic hold(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask
  // Counts alert-enable cycles or retry ticks over a window
  task automatic count(input int c, input logic pick);
    k = 0;
    repeat (c) begin
      @(negedge ref_clk_i);
      k += int'(pick ? tick : oe);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    wrap_up();
  end

  initial begin
    reset_i = 1'b1;
    core_ok = 1'b1;
    io_ok = 1'b1;
    sd_n = 1'b1;
    dev_act = 1'b0;
    for (n = 0; n < 5; n++) evt[n] = 8'h00;
    hold(6);
    reset_i = 1'b0;
    hold(4);
    for (n = 0; n < 5; n++) rchk(`OFS_MASK_BASE + 4'(n), mask_rst[n]);
    for (n = 0; n < 5; n++) rchk(`OFS_LATCH_BASE + 4'(n), 8'h00);
    rchk(`OFS_CFG, `CFG_RST);
    rchk(4'hb, 8'h00);
    $display("test defaults done");
    // Everything masked: latches fill but the pin stays quiet
    for (n = 0; n < 5; n++) u_host.wr(`OFS_MASK_BASE + 4'(n), 8'hff);
    for (n = 0; n < 5; n++) rchk(`OFS_MASK_BASE + 4'(n), impl[n]);
    for (n = 0; n < 5; n++) pulse(n, 8'hff);
    hold(3);
    check({7'h0, oe}, 8'h00);
    rchk(`OFS_LATCH_BASE, impl[0] & 8'hfd);
    for (n = 1; n < 5; n++) rchk(`OFS_LATCH_BASE + 4'(n), impl[n]);
    for (n = 0; n < 5; n++) u_host.wr(`OFS_MASK_BASE + 4'(n), mask_rst[n]);
    hold(3);
    check({7'h0, line}, 8'h00);
    u_host.wr(`OFS_CFG, 8'h0b);
    hold(3);
    check({6'h0, pu, line}, 8'h03);
    u_host.clear(8'h02);
    hold(2);
    rchk(`OFS_CFG, 8'h02);
    for (n = 0; n < 5; n++) rchk(`OFS_LATCH_BASE + 4'(n), 8'h00);
    check({7'h0, line}, 8'h01);
    $display("test mask and clear done");
    // Thermal warning is masked by default, over-temperature is not
    pulse(1, 8'h10);
    hold(3);
    check({7'h0, oe}, 8'h00);
    pulse(3, 8'h80);
    hold(3);
    check({7'h0, oe}, 8'h01);
    u_host.wr(`OFS_CFG, 8'h06);
    hold(4);
    count(32, 1'b0);
    check(8'(k), 8'h10);
    $display("test pulse mode done");
    u_host.wr(`OFS_CFG, 8'h12);
    hold(15);
    count(120, 1'b1);
    check(8'(k), 8'h0a);
    u_host.wr(`OFS_CFG, 8'h02);
    hold(45);
    count(120, 1'b1);
    check(8'(k), 8'h03);
    $display("test retry done");
    sd_n = 1'b0;
    hold(5);
    sd_n = 1'b1;
    hold(3);
    rchk(`OFS_LATCH_BASE + 4'h3, 8'h00);
    dev_act = 1'b1;
    rchk(`OFS_LATCH_BASE, 8'h02);
    dev_act = 1'b0;
    $display("test shutdown and active done");
    // Soft reset wipes latches and configuration
    pulse(2, 8'h81);
    u_host.wr(`OFS_MASK_BASE, 8'h00);
    u_host.wr(`OFS_CFG, 8'h4b);
    for (n = 0; n < 8 && srst !== 1'b1; n++) @(negedge ref_clk_i);
    check({7'h0, srst}, 8'h01);
    if (srst !== 1'b1) wrap_up();
    hold(4);
    rchk(`OFS_MASK_BASE, `MASK_RST_0);
    rchk(`OFS_CFG, `CFG_RST);
    rchk(`OFS_LATCH_BASE + 4'h2, 8'h00);
    $display("test soft reset done");
    // Supply dips act like a full reset
    u_host.wr(`OFS_CFG, 8'h0b);
    core_ok = 1'b0;
    hold(6);
    check({7'h0, crst}, 8'h01);
    core_ok = 1'b1;
    io_ok = 1'b0;
    hold(6);
    check({7'h0, crst}, 8'h01);
    io_ok = 1'b1;
    hold(6);
    check({7'h0, crst}, 8'h00);
    rchk(`OFS_CFG, `CFG_RST);
    $display("test supply dip done");
    wrap_up();
  end
endmodule
